// ### logic/core_alu_defs.vh
// constants for the 8-bit datapath core: offsets, fields, opcodes, reset values
`ifndef CORE_ALU_DEFS_VH
`define CORE_ALU_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets on the axi4-lite slave
// ----------------------------------------------------------------
`define OFS_INSTR      8'h00
`define OFS_STATUS     8'h04
`define OFS_WORK       8'h08
`define OFS_PROD       8'h0c
`define OFS_PC         8'h10
`define OFS_FILE_HI    2'b01
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// ----------------------------------------------------------------
// flag positions in alu_status_register, busy bit in status word
// ----------------------------------------------------------------
`define FLG_C          0
`define FLG_DIG        1
`define FLG_Z          2
`define FLG_OVF        3
`define STAT_BUSY      8
`define STAT_RST       4'h0
`define PC_RST         16'h0000
`define BYTE_RST       8'h00

// ----------------------------------------------------------------
// data-space addresses of mapped special registers
// ----------------------------------------------------------------
`define FA_WORK        4'h8
`define FA_STAT        4'h9
`define FA_PCL         4'ha
`define FA_PCH         4'hb
`define FA_PRODL       4'hc
`define FA_PRODH       4'hd

// ----------------------------------------------------------------
// opcode field [15:12]
// ----------------------------------------------------------------
`define OP_NOP         4'h0
`define OP_ADD         4'h1
`define OP_SUB         4'h2
`define OP_AND         4'h3
`define OP_OR          4'h4
`define OP_XOR         4'h5
`define OP_ROL         4'h6
`define OP_ROR         4'h7
`define OP_LOAD_W      4'h8
`define OP_STORE_W     4'h9
`define OP_MUL         4'ha
`define OP_COPY        4'hb
`define OP_ADD_K       4'hc
`define OP_SUB_K       4'hd
`define OP_GOTO        4'he
`define OP_LOAD_K      4'hf

`endif

// ### logic/alu_unit.v
// 8-bit two's complement alu with carry, digit carry, zero and overflow
`include "core_alu_defs.vh"

module alu_unit (
    // operation
    input  wire [3:0] op,
    input  wire       c_in,
    // operands
    input  wire [7:0] f_opd,
    input  wire [7:0] w_opd,
    input  wire [7:0] lit,
    // result and flags
    output reg  [7:0] res,
    output reg  [3:0] flg,
    output reg  [3:0] upd
);

    reg [7:0] a_opd;
    reg [7:0] b_opd;
    reg       cin;
    reg [8:0] sum9;
    reg [4:0] lo5;

    always @* begin
        a_opd = ((op == `OP_ADD_K) || (op == `OP_SUB_K)) ? lit : f_opd;
        cin   = (op == `OP_SUB) || (op == `OP_SUB_K);
        // subtraction as a + ~b + 1, so carry reads as inverted borrow
        b_opd = cin ? ~w_opd : w_opd;
        sum9  = {1'b0, a_opd} + {1'b0, b_opd} + {8'h00, cin};
        lo5   = {1'b0, a_opd[3:0]} + {1'b0, b_opd[3:0]} + {4'h0, cin};
        res   = 8'h00;
        flg   = 4'h0;
        upd   = 4'h0;
        case (op)
            `OP_ADD, `OP_SUB, `OP_ADD_K, `OP_SUB_K: begin
                res          = sum9[7:0];
                flg[`FLG_C]  = sum9[8];
                flg[`FLG_DIG] = lo5[4];
                // only bit 6 into bit 7 of this byte matters
                flg[`FLG_OVF] = (a_opd[7] == b_opd[7]) && (sum9[7] != a_opd[7]);
                upd          = 4'hf;
            end
            `OP_AND: begin
                res = f_opd & w_opd;
                upd[`FLG_Z] = 1'b1;
            end
            `OP_OR: begin
                res = f_opd | w_opd;
                upd[`FLG_Z] = 1'b1;
            end
            `OP_XOR: begin
                res = f_opd ^ w_opd;
                upd[`FLG_Z] = 1'b1;
            end
            `OP_ROL: begin
                res         = {f_opd[6:0], c_in};
                flg[`FLG_C] = f_opd[7];
                upd[`FLG_C] = 1'b1;
            end
            `OP_ROR: begin
                res         = {c_in, f_opd[7:1]};
                flg[`FLG_C] = f_opd[0];
                upd[`FLG_C] = 1'b1;
            end
            `OP_LOAD_W: begin
                res = f_opd;
                upd[`FLG_Z] = 1'b1;
            end
            default: begin
                res = f_opd;
            end
        endcase
        flg[`FLG_Z] = (res == 8'h00);
    end

endmodule // alu_unit

// ### logic/mult_8x8.v
// unsigned 8x8 multiplier, full product settles within one cycle
module mult_8x8 (
    // operands
    input  wire [7:0]  mul_a,
    input  wire [7:0]  mul_b,
    // product
    output wire [15:0] product
);

    assign product = {8'h00, mul_a} * {8'h00, mul_b};

endmodule // mult_8x8

// ### logic/alu_core.v
// 8-bit core datapath: two-stage pipe, alu, multiplier, axi4-lite slave
//
// Overview of operation
// - alu works on 8-bit operands: add, subtract, rotate, logical ops.
// - arithmetic uses two's complement unless the opcode says otherwise.
// - instructions update carry, digit carry, zero and overflow in status; here only add/sub do, logic ops and load w set zero, rotates carry.
// - in subtraction carry and digit carry are inverted borrows.
// - overflow set when signed 8-bit result leaves -128..127.
// - overflow looks only at bits 6 and 7 of one byte.
// - unsigned 8x8 multiply gives full 16-bit product in one cycle.
// - alu ops take working register and any file register.
// - some ops move file register to file register bypassing working register.
// - fetch of next opcode overlaps execution of current one.
// - opcodes are 16-bit words fetched in one cycle, separate program path.
// - all instructions single cycle except branches.
// - special registers, pc and working register, live in data space.
// - program counter spans 64k words of 16 bits.
`include "core_alu_defs.vh"

module alu_core (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0]  file_ff [0:7];
    reg [7:0]  working_register_ff;
    reg [3:0]  alu_status_register_ff;
    reg [15:0] program_counter_ff;
    reg [7:0]  pc_latch_hi_ff;
    reg [15:0] prod_ff;
    reg [15:0] fetch_ir_ff;
    reg        fetch_vld_ff;
    reg [15:0] exe_ir_ff;
    reg        exe_vld_ff;
    reg        flush_ff;
    reg [7:0]  aw_addr_ff;
    reg        aw_have_ff;
    reg [31:0] w_data_ff;
    reg [3:0]  w_strb_ff;
    reg        w_have_ff;
    integer    i;

    // ----------------------------------------------------------------
    // execute stage decode
    // ----------------------------------------------------------------
    wire [3:0]  op      = exe_ir_ff[15:12];
    wire [3:0]  fa      = exe_ir_ff[11:8];
    wire        dst_f   = exe_ir_ff[7];
    wire [3:0]  fb      = exe_ir_ff[7:4];
    wire [7:0]  lit     = exe_ir_ff[7:0];
    wire        exe_go  = exe_vld_ff && !flush_ff;
    wire [7:0]  f_val;
    wire [7:0]  alu_res;
    wire [3:0]  alu_flg;
    wire [3:0]  alu_upd;
    wire [15:0] product;

    // data-space read port; special registers sit beside the file bytes
    function [7:0] data_rd;
        input [3:0] addr;
        begin
            case (addr)
                `FA_WORK:  data_rd = working_register_ff;
                `FA_STAT:  data_rd = {4'h0, alu_status_register_ff};
                `FA_PCL:   data_rd = program_counter_ff[7:0];
                `FA_PCH:   data_rd = pc_latch_hi_ff;
                `FA_PRODL: data_rd = prod_ff[7:0];
                `FA_PRODH: data_rd = prod_ff[15:8];
                default:   data_rd = addr[3] ? 8'h00 : file_ff[addr[2:0]];
            endcase
        end
    endfunction

    assign f_val = data_rd(fa);

    alu_unit alu_unit_inst (
        .op    (op),
        .c_in  (alu_status_register_ff[`FLG_C]),
        .f_opd (f_val),
        .w_opd (working_register_ff),
        .lit   (lit),
        .res   (alu_res),
        .flg   (alu_flg),
        .upd   (alu_upd)
    );

    mult_8x8 mult_8x8_inst (
        .mul_a   (working_register_ff),
        .mul_b   (f_val),
        .product (product)
    );

    // ----------------------------------------------------------------
    // result write-back selection
    // ----------------------------------------------------------------
    reg       wb_en;
    reg [3:0] wb_addr;
    reg [7:0] wb_data;
    reg       branch;

    always @* begin
        wb_en   = 1'b0;
        wb_addr = `FA_WORK;
        wb_data = alu_res;
        branch  = 1'b0;
        case (op)
            `OP_ADD, `OP_SUB, `OP_AND, `OP_OR,
            `OP_XOR, `OP_ROL, `OP_ROR: begin
                wb_en   = 1'b1;
                wb_addr = dst_f ? fa : `FA_WORK;
            end
            `OP_LOAD_W, `OP_ADD_K, `OP_SUB_K: begin
                wb_en = 1'b1;
            end
            `OP_LOAD_K: begin
                wb_en   = 1'b1;
                wb_data = lit;
            end
            `OP_STORE_W: begin
                wb_en   = 1'b1;
                wb_addr = fa;
                wb_data = working_register_ff;
            end
            `OP_COPY: begin
                // straight file-to-file, working register untouched
                wb_en   = 1'b1;
                wb_addr = fb;
                wb_data = f_val;
            end
            `OP_GOTO: begin
                branch = 1'b1;
            end
            default: begin
                wb_en = 1'b0;
            end
        endcase
        // writing pc low is a computed jump and costs the same as a branch
        if (wb_en && (wb_addr == `FA_PCL))
            branch = 1'b1;
        if (!exe_go) begin
            wb_en  = 1'b0;
            branch = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write side
    // ----------------------------------------------------------------
    wire aw_fire   = s_axi_awvalid && s_axi_awready;
    wire w_fire    = s_axi_wvalid && s_axi_wready;
    wire is_instr  = (aw_addr_ff == `OFS_INSTR);
    wire strb_ok   = w_strb_ff[0] && w_strb_ff[1];
    // an instruction can only enter fetch when no branch is draining
    wire fetch_ok  = !flush_ff && !branch;
    wire wr_ready  = aw_have_ff && w_have_ff && !s_axi_bvalid;
    wire wr_go     = wr_ready && (!(is_instr && strb_ok) || fetch_ok);
    wire fetch_take = wr_go && is_instr && strb_ok;

    wire nxt_aw_have = (aw_have_ff || aw_fire) && !wr_go;
    wire nxt_w_have  = (w_have_ff || w_fire) && !wr_go;
    wire nxt_bvalid  = wr_go || (s_axi_bvalid && !s_axi_bready);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_addr_ff    <= 8'h00;
            aw_have_ff    <= 1'b0;
            w_data_ff     <= 32'h0000_0000;
            w_strb_ff     <= 4'h0;
            w_have_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (aw_fire)
                aw_addr_ff <= s_axi_awaddr;
            if (w_fire) begin
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            aw_have_ff    <= nxt_aw_have;
            w_have_ff     <= nxt_w_have;
            s_axi_awready <= !nxt_aw_have && !nxt_bvalid;
            s_axi_wready  <= !nxt_w_have && !nxt_bvalid;
            s_axi_bvalid  <= nxt_bvalid;
            // only the instruction port is writable; a write without strobes 0 and 1 both set is refused
            // refused writes are still answered, so a master never waits forever
            if (wr_go)
                s_axi_bresp <= fetch_take ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // ----------------------------------------------------------------
    // two-stage pipe: fetch latches next opcode while execute runs
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_ir_ff  <= 16'h0000;
            fetch_vld_ff <= 1'b0;
            exe_ir_ff    <= 16'h0000;
            exe_vld_ff   <= 1'b0;
            flush_ff     <= 1'b0;
        end else begin
            if (fetch_take)
                fetch_ir_ff <= w_data_ff[15:0];
            fetch_vld_ff <= fetch_take;
            // opcode in fetch moves on as the current one executes
            exe_ir_ff    <= fetch_ir_ff;
            // a branch discards the opcode fetched beside it
            exe_vld_ff   <= fetch_vld_ff && !branch;
            flush_ff     <= branch;
        end
    end

    // ----------------------------------------------------------------
    // program counter, 16 bits wide for a 64k word space
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            program_counter_ff <= `PC_RST;
        end else if (exe_go && (op == `OP_GOTO)) begin
            // high byte always comes from the latch, never from the opcode
            program_counter_ff <= {pc_latch_hi_ff, lit};
        end else if (wb_en && (wb_addr == `FA_PCL)) begin
            program_counter_ff <= {pc_latch_hi_ff, wb_data};
        end else if (fetch_take) begin
            // wraps at the top of the space
            program_counter_ff <= program_counter_ff + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // data space write-back and status flags
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 8; i = i + 1)
                file_ff[i] <= `BYTE_RST;
            working_register_ff    <= `BYTE_RST;
            alu_status_register_ff <= `STAT_RST;
            pc_latch_hi_ff         <= `BYTE_RST;
            prod_ff                <= 16'h0000;
        end else begin
            if (exe_go) begin
                // flags not touched by this opcode keep their value
                alu_status_register_ff <= (alu_flg & alu_upd) |
                                          (alu_status_register_ff & ~alu_upd);
                if (op == `OP_MUL)
                    prod_ff <= product;
            end
            if (wb_en) begin
                case (wb_addr)
                    `FA_WORK:  working_register_ff <= wb_data;
                    // an explicit write to status beats the flag update
                    `FA_STAT:  alu_status_register_ff <= wb_data[3:0];
                    // pc low itself is loaded by the jump logic above
                    `FA_PCL:   pc_latch_hi_ff <= pc_latch_hi_ff;
                    `FA_PCH:   pc_latch_hi_ff <= wb_data;
                    `FA_PRODL: prod_ff[7:0] <= wb_data;
                    `FA_PRODH: prod_ff[15:8] <= wb_data;
                    default: begin
                        if (!wb_addr[3])
                            file_ff[wb_addr[2:0]] <= wb_data;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read side, data taken straight into rdata register
    // ----------------------------------------------------------------
    wire       ar_fire    = s_axi_arvalid && s_axi_arready;
    wire       nxt_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
    // busy spans fetch, execute and the slot drained after a branch
    wire       busy       = fetch_vld_ff || exe_vld_ff || flush_ff;
    // decoded from the live address, which the master holds until arready
    reg [31:0] rd_mux;
    reg [1:0]  rd_resp;

    always @* begin
        rd_mux  = 32'h0000_0000;
        rd_resp = `RESP_OKAY;
        case (s_axi_araddr)
            `OFS_INSTR:  rd_mux = 32'h0000_0000;
            `OFS_STATUS: rd_mux = {23'h000000, busy, 4'h0, alu_status_register_ff};
            `OFS_WORK:   rd_mux = {24'h000000, working_register_ff};
            `OFS_PROD:   rd_mux = {16'h0000, prod_ff};
            `OFS_PC:     rd_mux = {16'h0000, program_counter_ff};
            default: begin
                // data-space window: one byte per word
                if ((s_axi_araddr[7:6] == `OFS_FILE_HI) && (s_axi_araddr[1:0] == 2'b00)
                        && !(s_axi_araddr[5] && s_axi_araddr[4] && s_axi_araddr[3]))
                    rd_mux = {24'h000000, data_rd(s_axi_araddr[5:2])};
                else
                    rd_resp = `RESP_SLVERR;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_rvalid  <= nxt_rvalid;
            s_axi_arready <= !nxt_rvalid;
            if (ar_fire) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_resp;
            end
        end
    end

endmodule // alu_core

// ### testbench/alu_core_sva.sv
// bus-level assertion checker for the 8-bit core datapath
`include "core_alu_defs.vh"

module alu_core_sva (
    // clock and reset
    input logic        core_clk,
    input logic        rst_b,
    // write side
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0]  s_axi_wstrb,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    // read side
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready
);
    logic [7:0] aw_addr_ff;
    logic [3:0] w_strb_ff;
    logic [7:0] ar_addr_ff;
    logic       wr_ok;

    // ----------------------------------------------------------------
    // helper capture of the taken request
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_addr_ff <= 8'h00;
            w_strb_ff  <= 4'h0;
            ar_addr_ff <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_addr_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) w_strb_ff <= s_axi_wstrb;
            if (s_axi_arvalid && s_axi_arready) ar_addr_ff <= s_axi_araddr;
        end
    end
    // a partial opcode word is refused, never half executed
    assign wr_ok = (aw_addr_ff == `OFS_INSTR) && (w_strb_ff[1:0] == 2'b11);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answer;
        !s_axi_bvalid ##[1:3] s_axi_bvalid;
    endsequence

    wr_latency_a: assert property (wr_taken |=> wr_answer)
        else $error("write answer late");
    wr_resp_a: assert property (s_axi_bvalid |->
        s_axi_bresp == (wr_ok ? `RESP_OKAY : `RESP_SLVERR)) else $error("bad bresp");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("rdata moved");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    rd_unmapped_a: assert property (s_axi_rvalid && ar_addr_ff == 8'h7c |->
        s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
    rd_instr_a: assert property (s_axi_rvalid && ar_addr_ff == `OFS_INSTR |->
        s_axi_rdata == 32'h0 && s_axi_rresp == `RESP_OKAY) else $error("opcode reg read");
    stat_rsvd_a: assert property (s_axi_rvalid && ar_addr_ff == `OFS_STATUS |->
        s_axi_rdata[31:9] == 23'h0 && s_axi_rdata[7:4] == 4'h0) else $error("status spare bits");
endmodule // alu_core_sva

bind alu_core alu_core_sva alu_core_sva_inst (.*);

// ### testbench/alu_core_tb.sv
// self-checking bench for the 8-bit core datapath
`include "core_alu_defs.vh"

module alu_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b1;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    int          n_mismatch = 0;
    int          comparisons = 0;
    // opcode, read address, expected word
    logic [55:0] rows [27] = '{
        {16'hf0ff, 8'h08, 32'hff}, {16'h9000, 8'h40, 32'hff},
        {16'hf001, 8'h60, 32'h01}, {16'h1000, 8'h04, 32'h07},
        {16'hf07f, 8'h08, 32'h7f}, {16'h9100, 8'h44, 32'h7f},
        {16'hf001, 8'h08, 32'h01}, {16'h1100, 8'h04, 32'h0a},
        {16'h2100, 8'h04, 32'h0a}, {16'hf001, 8'h08, 32'h01},
        {16'hd001, 8'h04, 32'h07}, {16'hf001, 8'h08, 32'h01},
        {16'hd010, 8'h04, 32'h01}, {16'hf0ff, 8'h08, 32'hff},
        {16'ha000, 8'h0c, 32'hfe01}, {16'hb020, 8'h48, 32'hff},
        {16'hf00f, 8'h04, 32'h01}, {16'h3000, 8'h08, 32'h0f},
        {16'h5080, 8'h40, 32'hf0}, {16'h4000, 8'h08, 32'hff},
        {16'h6000, 8'h08, 32'he1}, {16'h7000, 8'h08, 32'hf8},
        {16'h7000, 8'h08, 32'h78}, {16'hf000, 8'h08, 32'h00},
        {16'h3000, 8'h04, 32'h04}, {16'he012, 8'h10, 32'h12},
        {16'hf05a, 8'h08, 32'h5a}};

    always #2 core_clk = ~core_clk;

    alu_core alu_core_inst (
        .core_clk(core_clk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
    endtask

    // stall holds bready low that many cycles after bvalid shows
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er, input int stall);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (stall == 0);
        do begin
            @(posedge core_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        if (stall > 0) begin
            repeat (stall) @(posedge core_clk);
            s_axi_bready <= 1'b1;
            @(posedge core_clk);
        end
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                            input int stall);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        if (stall > 0) begin
            repeat (stall) @(posedge core_clk);
            s_axi_rready <= 1'b1;
            @(posedge core_clk);
        end
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        if (er == `RESP_OKAY) check("rdata", ed, s_axi_rdata);
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        do_reset();
        for (int i = 0; i < 27; i++) begin
            axi_write(`OFS_INSTR, {16'h0, rows[i][55:40]}, 4'hf, `RESP_OKAY, (i == 3) ? 3 : 0);
            // the opcode retires one edge after its write is answered
            @(posedge core_clk);
            axi_read(rows[i][39:32], rows[i][31:0], `RESP_OKAY, (i == 3) ? 3 : 0);
        end
        // half an opcode word and a write to a read-only place are both refused
        axi_write(`OFS_INSTR, 32'h0000_f0aa, 4'h1, `RESP_SLVERR, 0);
        axi_write(`OFS_STATUS, 32'h0000_000f, 4'hf, `RESP_SLVERR, 0);
        axi_read(`OFS_WORK, 32'h5a, `RESP_OKAY, 0);
        axi_read(`OFS_INSTR, 32'h0, `RESP_OKAY, 0);
        axi_read(8'h7c, 32'h0, `RESP_SLVERR, 0);
        // back-to-back opcodes, carry out of bit 7 with no digit carry
        axi_write(`OFS_INSTR, 32'h0000_f011, 4'hf, `RESP_OKAY, 0);
        axi_write(`OFS_INSTR, 32'h0000_1000, 4'hf, `RESP_OKAY, 0);
        // second opcode still in execute: busy shows, its flags not yet
        axi_read(`OFS_STATUS, 32'h104, `RESP_OKAY, 0);
        axi_read(`OFS_STATUS, 32'h01, `RESP_OKAY, 0);
        axi_read(`OFS_WORK, 32'h01, `RESP_OKAY, 0);
        do_reset();
        axi_read(`OFS_WORK, 32'h0, `RESP_OKAY, 0);
        axi_read(`OFS_STATUS, 32'h0, `RESP_OKAY, 0);
        axi_read(`OFS_PC, 32'h0, `RESP_OKAY, 0);
        finish_test();
    end

    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
endmodule // alu_core_tb
